// [src/scb_pkg.sv]
// Shared constants and carrier types for the CAM bridge
package scb_pkg;
	localparam int DATA_W = 32;
	localparam int STAGE_W = 72;
	localparam int BEAT_W = 36;
	localparam int CTX_N = 32;
	localparam int CTX_W = 5;
	localparam int ADDR_W = 6;
	localparam int SA_W = 26;
	localparam int BUF_DEPTH = 2;
	// Word indices on host address bits 7:2
	localparam logic [5:0] IDX_WDATA0 = 6'h00;
	localparam logic [5:0] IDX_WDATA1 = 6'h01;
	localparam logic [5:0] IDX_WDATA2 = 6'h02;
	localparam logic [5:0] IDX_LAUNCH = 6'h03;
	localparam logic [5:0] IDX_STATUS = 6'h04;
	localparam logic [5:0] IDX_SEMA = 6'h05;
	localparam logic [5:0] IDX_RDATA0 = 6'h08;
	localparam logic [5:0] IDX_RDATA1 = 6'h09;
	localparam logic [5:0] IDX_RDATA2 = 6'h0a;
	// Field positions
	localparam int LAUNCH_SEARCH_BIT = 8;
	localparam int LAUNCH_RD_BIT = 9;
	localparam int RES_VALID_BIT = 31;
	localparam int RES_HIT_BIT = 29;
	localparam int RES_MULTI_BIT = 28;
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_OVF_BIT = 1;
	localparam int STAT_FULL_BIT = 2;
	// Reset values
	localparam logic [31:0] SEMA_RST = 32'h0;
	localparam logic [31:0] RESVLD_RST = 32'h0;

	typedef struct packed {
		logic search;
		logic want_rd;
		logic [CTX_W-1:0] ctx;
		logic [STAGE_W-1:0] data;
	} scb_cmd_t;

	typedef struct packed {
		logic hit;
		logic multi;
		logic [SA_W-1:0] addr;
	} scb_res_t;
endpackage : scb_pkg

// [src/scb_buf.sv]
// Small valid/ready buffer for launched commands
`timescale 1ns/1ps
`default_nettype none
module scb_buf #(
	parameter int W = 8,
	parameter int DEPTH = 2
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Fill side
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [W-1:0] in_data_i,
	// Drain side
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [W-1:0] out_data_o
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);
	logic [W-1:0] mem [DEPTH];
	logic [PW-1:0] wr_q, wr_d, rd_q, rd_d;
	logic [CW-1:0] cnt_q, cnt_d;
	logic push, pop;

	function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
		return (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
	endfunction : bump

	always_comb begin
		push = in_valid_i && (cnt_q != CW'(DEPTH));
		pop = out_ready_i && (cnt_q != '0);
		wr_d = push ? bump(wr_q) : wr_q;
		rd_d = pop ? bump(rd_q) : rd_q;
		cnt_d = CW'(cnt_q + CW'(push) - CW'(pop));
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
		end else begin
			wr_q <= wr_d;
			rd_q <= rd_d;
			cnt_q <= cnt_d;
		end
	end

	always_ff @(posedge clk_i) begin
		if (push) begin
			mem[wr_q] <= in_data_i;
		end
	end

	assign in_ready_o = (cnt_q != CW'(DEPTH));
	assign out_valid_o = (cnt_q != '0);
	assign out_data_o = mem[rd_q];
endmodule : scb_buf
`default_nettype wire

// [src/scb_bridge.sv]
// SRAM-style host registers bridged onto a CAM search port
`timescale 1ns/1ps
`default_nettype none
module scb_bridge
	import scb_pkg::*;
#(
	parameter int DEPTH = BUF_DEPTH
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Host SRAM bus
	input wire logic cs_n_i,
	input wire logic rw_i,
	input wire logic [ADDR_W-1:0] addr_i,
	input wire logic [DATA_W-1:0] wdata_i,
	input wire logic oe_n_i,
	input wire logic late_wr_i,
	output logic [DATA_W-1:0] rdata_o,
	output logic rdata_oe_o,
	// CAM search port outputs
	output logic [BEAT_W-1:0] search_data_rise_o,
	output logic [BEAT_W-1:0] search_data_fall_o,
	output logic search_data_oe_o,
	output logic search_select_n_o,
	output logic search_kind_o,
	output logic [CTX_W-1:0] search_ctx_o,
	// CAM inputs
	input wire logic [BEAT_W-1:0] search_data_i,
	input wire logic cam_ready_i,
	input wire logic rd_valid_i,
	input wire logic res_valid_i,
	input wire logic [CTX_W-1:0] res_ctx_i,
	input wire logic res_hit_i,
	input wire logic res_multi_i,
	input wire logic [SA_W-1:0] res_addr_i
);
	typedef enum logic [1:0] {S_IDLE, S_WAIT, S_FALL} scb_state_t;

	logic wr_now, rd_now, wr_go, push, pop, busy, buf_in_ready, buf_out_valid;
	logic [ADDR_W-1:0] wr_addr;
	logic [ADDR_W:0] lag1_q, lag1_d, lag2_q, lag2_d;
	logic [STAGE_W-1:0] stage_q, stage_d, rd_data_q, rd_data_d;
	logic [DATA_W-1:0] sema_q, sema_d, rdata_q, rdata_d, rword;
	logic [CTX_N-1:0] res_vld_q, res_vld_d;
	logic ovf_q, ovf_d, roe_q, roe_d;
	logic [CTX_W-1:0] launch_ctx, ctx_q, ctx_d;
	logic [BEAT_W-1:0] rise_q, rise_d, fstage_q, fstage_d, fall_q, fall_in_q;
	logic [BEAT_W-1:0] rd_rise_q, rd_rise_d, buf_out_hi;
	logic sel_n_q, sel_n_d, bus_oe_q, bus_oe_d, kind_q, kind_d;
	scb_state_t state_q, state_d;
	scb_cmd_t push_cmd, buf_out;
	scb_res_t res_mem [CTX_N];

	// write data lags two edges in pipelined mode
	always_comb begin
		wr_now = !cs_n_i && !rw_i;
		rd_now = !cs_n_i && rw_i;
		lag1_d = {wr_now, addr_i};
		lag2_d = lag1_q;
		wr_go = late_wr_i ? lag2_q[ADDR_W] : wr_now;
		wr_addr = late_wr_i ? lag2_q[ADDR_W-1:0] : addr_i;
		launch_ctx = wdata_i[CTX_W-1:0];
		push = wr_go && (wr_addr == IDX_LAUNCH);
		push_cmd.search = wdata_i[LAUNCH_SEARCH_BIT];
		push_cmd.want_rd = wdata_i[LAUNCH_RD_BIT];
		push_cmd.ctx = launch_ctx;
		push_cmd.data = stage_q;
		busy = buf_out_valid || (state_q != S_IDLE);
	end

	always_comb begin
		stage_d = stage_q;
		sema_d = sema_q;
		ovf_d = ovf_q;
		res_vld_d = res_vld_q;
		if (wr_go) begin
			case (wr_addr)
				IDX_WDATA0: stage_d[31:0] = wdata_i;
				IDX_WDATA1: stage_d[63:32] = wdata_i;
				IDX_WDATA2: stage_d[71:64] = wdata_i[7:0];
				IDX_STATUS: ovf_d = 1'b0;
				IDX_SEMA: begin
					if (wdata_i == '0 || sema_q == '0) begin
						sema_d = wdata_i;
					end
				end
				default: ;
			endcase
		end
		// full buffer drops launch, flags it
		if (push && !buf_in_ready) begin
			ovf_d = 1'b1;
		end
		// clear on accepted search launch, set on result
		if (push && buf_in_ready && push_cmd.search) begin
			res_vld_d[launch_ctx] = 1'b0;
		end
		if (res_valid_i) begin
			res_vld_d[res_ctx_i] = 1'b1;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			res_mem <= '{default: '0};
		end else if (res_valid_i) begin
			res_mem[res_ctx_i] <= '{hit: res_hit_i, multi: res_multi_i, addr: res_addr_i};
		end
	end

	always_comb begin
		rword = '0;
		if (addr_i[ADDR_W-1]) begin
			rword[RES_VALID_BIT] = res_vld_q[addr_i[CTX_W-1:0]];
			rword[RES_HIT_BIT] = res_mem[addr_i[CTX_W-1:0]].hit;
			rword[RES_MULTI_BIT] = res_mem[addr_i[CTX_W-1:0]].multi;
			rword[SA_W-1:0] = res_mem[addr_i[CTX_W-1:0]].addr;
		end else begin
			case (addr_i)
				IDX_WDATA0: rword = stage_q[31:0];
				IDX_WDATA1: rword = stage_q[63:32];
				IDX_WDATA2: rword[7:0] = stage_q[71:64];
				IDX_STATUS: begin
					rword[STAT_BUSY_BIT] = busy;
					rword[STAT_OVF_BIT] = ovf_q;
					rword[STAT_FULL_BIT] = !buf_in_ready;
				end
				IDX_SEMA: rword = sema_q;
				IDX_RDATA0: rword = rd_data_q[31:0];
				IDX_RDATA1: rword = rd_data_q[63:32];
				IDX_RDATA2: rword[7:0] = rd_data_q[71:64];
				default: ;
			endcase
		end
		// read data one edge after select
		rdata_d = rd_now ? rword : rdata_q;
		roe_d = rd_now && !oe_n_i;
	end

	scb_buf #(
		.W($bits(scb_cmd_t)),
		.DEPTH(DEPTH)
	) u_buf (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.in_valid_i(push),
		.in_ready_o(buf_in_ready),
		.in_data_i(push_cmd),
		.out_valid_o(buf_out_valid),
		.out_ready_i(pop),
		.out_data_o(buf_out)
	);

	always_comb begin
		state_d = state_q;
		pop = 1'b0;
		sel_n_d = 1'b1;
		bus_oe_d = 1'b0;
		rise_d = rise_q;
		fstage_d = fstage_q;
		kind_d = kind_q;
		ctx_d = ctx_q;
		rd_rise_d = rd_rise_q;
		rd_data_d = rd_data_q;
		buf_out_hi = buf_out.data[STAGE_W-1:BEAT_W];
		unique case (state_q)
			S_IDLE: begin
				if (buf_out_valid && cam_ready_i) begin
					pop = 1'b1;
					sel_n_d = 1'b0;
					bus_oe_d = 1'b1;
					// upper half on rising beat, lower on falling
					rise_d = buf_out_hi;
					fstage_d = buf_out.data[BEAT_W-1:0];
					kind_d = buf_out.search;
					ctx_d = buf_out.ctx;
					if (buf_out.want_rd) begin
						state_d = S_WAIT;
					end
				end
			end
			S_WAIT: begin
				if (rd_valid_i) begin
					rd_rise_d = search_data_i;
					state_d = S_FALL;
				end
			end
			S_FALL: begin
				rd_data_d = {rd_rise_q, fall_in_q};
				state_d = S_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			lag1_q <= '0;
			lag2_q <= '0;
			stage_q <= '0;
			sema_q <= SEMA_RST;
			ovf_q <= 1'b0;
			res_vld_q <= RESVLD_RST;
			rdata_q <= '0;
			roe_q <= 1'b0;
			state_q <= S_IDLE;
			sel_n_q <= 1'b1;
			bus_oe_q <= 1'b0;
			rise_q <= '0;
			fstage_q <= '0;
			kind_q <= 1'b0;
			ctx_q <= '0;
			rd_rise_q <= '0;
			rd_data_q <= '0;
		end else begin
			lag1_q <= lag1_d;
			lag2_q <= lag2_d;
			stage_q <= stage_d;
			sema_q <= sema_d;
			ovf_q <= ovf_d;
			res_vld_q <= res_vld_d;
			rdata_q <= rdata_d;
			roe_q <= roe_d;
			state_q <= state_d;
			sel_n_q <= sel_n_d;
			bus_oe_q <= bus_oe_d;
			rise_q <= rise_d;
			fstage_q <= fstage_d;
			kind_q <= kind_d;
			ctx_q <= ctx_d;
			rd_rise_q <= rd_rise_d;
			rd_data_q <= rd_data_d;
		end
	end

	always_ff @(negedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			fall_q <= '0;
			fall_in_q <= '0;
		end else begin
			fall_q <= fstage_q;
			fall_in_q <= search_data_i;
		end
	end

	assign rdata_o = rdata_q;
	assign rdata_oe_o = roe_q;
	// both beats drive the 36-bit bus
	assign search_data_rise_o = rise_q;
	assign search_data_fall_o = fall_q;
	assign search_data_oe_o = bus_oe_q;
	assign search_select_n_o = sel_n_q;
	assign search_kind_o = kind_q;
	assign search_ctx_o = ctx_q;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	sequence s_late_wr;
		late_wr_i && wr_now && addr_i == IDX_WDATA0 ##2 late_wr_i;
	endsequence
	sequence s_rd_beat;
		state_q == S_WAIT && rd_valid_i ##1 state_q == S_FALL;
	endsequence

	property p_sema_hold;
		wr_go && wr_addr == IDX_SEMA && wdata_i != '0 && sema_q != '0 |=> $stable(sema_q);
	endproperty
	a_sema_hold: assert property (p_sema_hold) else $error("semaphore overwritten");
	property p_sema_free;
		wr_go && wr_addr == IDX_SEMA && wdata_i == '0 |=> sema_q == '0;
	endproperty
	a_sema_free: assert property (p_sema_free) else $error("semaphore not freed");
	property p_ctx_clear;
		push && buf_in_ready && push_cmd.search && !(res_valid_i && res_ctx_i == launch_ctx)
			|=> !res_vld_q[$past(launch_ctx)];
	endproperty
	a_ctx_clear: assert property (p_ctx_clear) else $error("context flag not cleared");
	property p_ctx_set;
		res_valid_i |=> res_vld_q[$past(res_ctx_i)];
	endproperty
	a_ctx_set: assert property (p_ctx_set) else $error("context flag not set");
	property p_read_lat;
		rd_now && !oe_n_i |=> rdata_oe_o && rdata_o == $past(rword) ##1 !rdata_oe_o || $past(rd_now);
	endproperty
	a_read_lat: assert property (p_read_lat) else $error("read answer late or wrong");
	property p_late_write;
		s_late_wr |=> stage_q[31:0] == $past(wdata_i);
	endproperty
	a_late_write: assert property (p_late_write) else $error("late write misplaced");
	property p_issue;
		pop |=> !search_select_n_o && search_data_oe_o && search_data_rise_o == $past(buf_out_hi);
	endproperty
	a_issue: assert property (p_issue) else $error("burst not issued");
	property p_busy;
		push && buf_in_ready |=> busy ##0 !ovf_q || $past(ovf_q);
	endproperty
	a_busy: assert property (p_busy) else $error("busy not shown");
	property p_capture;
		s_rd_beat |=> rd_data_q[STAGE_W-1:BEAT_W] == $past(search_data_i, 2);
	endproperty
	a_capture: assert property (p_capture) else $error("read data not captured");
	property p_ovf;
		push && !buf_in_ready |=> ovf_q ##1 (ovf_q || $past(wr_go && wr_addr == IDX_STATUS));
	endproperty
	a_ovf: assert property (p_ovf) else $error("dropped launch not flagged");
endmodule : scb_bridge
`default_nettype wire

// [verification/scb_cam_model.sv]
// Behavioural CAM search port for the bridge bench
`timescale 1ns/1ps
`default_nettype none
module scb_cam_model
	import scb_pkg::*;
(
	// Bench control
	input wire logic clk_i,
	input wire logic stall_i,
	input wire logic [3:0] lat_i,
	// Commands from bridge
	input wire logic [BEAT_W-1:0] rise_i,
	input wire logic [BEAT_W-1:0] fall_i,
	input wire logic sel_n_i,
	input wire logic kind_i,
	input wire logic [CTX_W-1:0] ctx_i,
	// Answers to bridge
	output logic [BEAT_W-1:0] bus_o,
	output logic ready_o,
	output logic rd_valid_o,
	output logic res_valid_o,
	output logic [CTX_W-1:0] res_ctx_o,
	output logic res_hit_o,
	output logic res_multi_o,
	output logic [SA_W-1:0] res_addr_o
);
	logic [77:0] q[$];
	logic [77:0] c;
	always @(negedge clk_i) begin
		#1;
		if (!sel_n_i) begin
			q.push_back({kind_i, ctx_i, rise_i, fall_i});
		end
	end
	initial begin
		{bus_o, rd_valid_o, res_valid_o, res_ctx_o, res_hit_o, res_multi_o, res_addr_o} = '0;
		ready_o = 1'b0;
		forever begin
			@(posedge clk_i);
			#1;
			ready_o = !stall_i;
			rd_valid_o = 1'b0;
			res_valid_o = 1'b0;
			// Released bus toggles
			bus_o = ~bus_o;
			if (q.size() > 0) begin
				c = q.pop_front();
				repeat (lat_i) @(posedge clk_i);
				#1;
				if (c[77]) begin
					res_valid_o = 1'b1;
					res_ctx_o = c[76:72];
					res_hit_o = 1'b1;
					res_multi_o = c[26];
					res_addr_o = c[25:0];
				end else if (c[71]) begin
					// upper half rising, lower half falling
					rd_valid_o = 1'b1;
					bus_o = c[71:36];
					@(posedge clk_i);
					#1;
					rd_valid_o = 1'b0;
					bus_o = c[35:0];
				end
			end
		end
	end
endmodule : scb_cam_model
`default_nettype wire

// [verification/scb_bridge_bench.sv]
// Self-checking bench for the CAM bridge
`timescale 1ns/1ps
`default_nettype none
module scb_bridge_bench
	import scb_pkg::*;
;
	typedef struct packed {logic wr; logic [5:0] idx; logic [31:0] val;} scb_row_t;
	logic clk_i, rst_n_i, cs_n_i, rw_i, oe_n_i, late_wr_i, rdata_oe_o, stall;
	logic [5:0] addr_i;
	logic [31:0] wdata_i, rdata_o;
	logic [BEAT_W-1:0] sdr, sdf, cam_data;
	logic sdoe, sel_n, kind, rdy, rdv, resv, hit, multi;
	logic [CTX_W-1:0] ctx, resctx;
	logic [SA_W-1:0] raddr;
	logic [3:0] lat;
	logic [79:0] last;
	logic [71:0] s, m;
	int n_mismatch, checks, n_cmd;
	scb_row_t rows [12] = '{'{1'b0, IDX_SEMA, 32'h0}, '{1'b0, IDX_STATUS, 32'h0},
		'{1'b0, 6'h06, 32'h0}, '{1'b1, IDX_SEMA, 32'h5}, '{1'b0, IDX_SEMA, 32'h5},
		'{1'b1, IDX_SEMA, 32'h7}, '{1'b0, IDX_SEMA, 32'h5}, '{1'b1, IDX_SEMA, 32'h0},
		'{1'b0, IDX_SEMA, 32'h0}, '{1'b1, 6'h07, 32'haaaa}, '{1'b0, 6'h07, 32'h0},
		'{1'b0, IDX_SEMA, 32'h0}};

	scb_bridge dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .cs_n_i(cs_n_i), .rw_i(rw_i),
		.addr_i(addr_i), .wdata_i(wdata_i), .oe_n_i(oe_n_i), .late_wr_i(late_wr_i),
		.rdata_o(rdata_o), .rdata_oe_o(rdata_oe_o), .search_data_rise_o(sdr),
		.search_data_fall_o(sdf), .search_data_oe_o(sdoe), .search_select_n_o(sel_n),
		.search_kind_o(kind), .search_ctx_o(ctx), .search_data_i(cam_data), .cam_ready_i(rdy),
		.rd_valid_i(rdv), .res_valid_i(resv), .res_ctx_i(resctx), .res_hit_i(hit),
		.res_multi_i(multi), .res_addr_i(raddr));
	scb_cam_model cam (.clk_i(clk_i), .stall_i(stall), .lat_i(lat), .rise_i(sdr),
		.fall_i(sdf), .sel_n_i(sel_n), .kind_i(kind), .ctx_i(ctx), .bus_o(cam_data),
		.ready_o(rdy), .rd_valid_o(rdv), .res_valid_o(resv), .res_ctx_o(resctx),
		.res_hit_o(hit), .res_multi_o(multi), .res_addr_o(raddr));

	always #2.5 clk_i = ~clk_i;
	// Burst read once the falling half stands
	always @(negedge clk_i) begin
		#1;
		if (!sel_n) begin
			n_cmd++;
			last = {1'b0, sdoe, kind, ctx, sdr, sdf};
		end
	end

	task automatic test_done;
		if (n_mismatch == 0 && checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : test_done

	task automatic cmp(input string nm, input logic [79:0] e, input logic [79:0] g);
		checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("unexpected %s expected %h seen %h", nm, e, g);
		end
	endtask : cmp

	task automatic wr(input logic [5:0] idx, input logic [31:0] v);
		cs_n_i = 1'b0;
		rw_i = 1'b0;
		addr_i = idx;
		wdata_i = late_wr_i ? ~v : v;
		@(negedge clk_i);
		cs_n_i = 1'b1;
		wdata_i = v;
		repeat (2) @(negedge clk_i);
	endtask : wr

	task automatic rd(input logic [5:0] idx, input logic [31:0] mk, input logic [31:0] e);
		cs_n_i = 1'b0;
		rw_i = 1'b1;
		addr_i = idx;
		oe_n_i = 1'b0;
		@(negedge clk_i);
		cs_n_i = 1'b1;
		oe_n_i = 1'b1;
		cmp("rdata", {48'h0, e}, {48'h0, rdata_o & mk});
		cmp("rdata_oe", 80'h1, {79'h0, rdata_oe_o});
		@(negedge clk_i);
		cmp("rdata_oe", 80'h0, {79'h0, rdata_oe_o});
	endtask : rd

	task automatic stg(input logic [71:0] v);
		wr(IDX_WDATA0, v[31:0]);
		wr(IDX_WDATA1, v[63:32]);
		wr(IDX_WDATA2, {24'h0, v[71:64]});
	endtask : stg

	function automatic logic [31:0] rexp(input logic [71:0] v);
		return {3'b101, v[26], 2'b00, v[25:0]};
	endfunction : rexp

	initial begin
		#100000;
		n_mismatch++;
		test_done();
	end

	initial begin
		{clk_i, rst_n_i, cs_n_i, rw_i, oe_n_i, late_wr_i, stall} = 7'b0011100;
		{addr_i, wdata_i, lat} = '0;
		repeat (6) @(negedge clk_i);
		cmp("reset", 80'h4, {77'h0, sel_n, sdoe, rdata_oe_o});
		rst_n_i = 1'b1;
		foreach (rows[i]) begin
			if (rows[i].wr) begin
				wr(rows[i].idx, rows[i].val);
			end else begin
				rd(rows[i].idx, 32'hffffffff, rows[i].val);
			end
		end
		late_wr_i = 1'b1;
		wr(IDX_SEMA, 32'h11);
		rd(IDX_SEMA, 32'hffffffff, 32'h11);
		s = 72'ha5123456789abcdef0;
		stg(s);
		rd(IDX_WDATA0, 32'hffffffff, s[31:0]);
		rd(IDX_WDATA1, 32'hffffffff, s[63:32]);
		rd(IDX_WDATA2, 32'hffffffff, {24'h0, s[71:64]});
		late_wr_i = 1'b0;
		cmp("cmds", 80'h0, 80'(n_cmd));
		wr(IDX_LAUNCH, 32'h103);
		wr(IDX_SEMA, 32'h0);
		repeat (4) @(negedge clk_i);
		cmp("cmd", {3'b011, 5'd3, s}, last);
		rd(6'h23, 32'hffffffff, rexp(s));
		rd(IDX_SEMA, 32'hffffffff, 32'h0);
		lat = 4'd3;
		m = 72'h800f0f1e1e2d2d3c3c;
		stg(m);
		wr(IDX_LAUNCH, 32'h200);
		repeat (8) @(negedge clk_i);
		cmp("cmd", {3'b010, 5'd0, m}, last);
		rd(IDX_RDATA0, 32'hffffffff, m[31:0]);
		rd(IDX_RDATA1, 32'hffffffff, m[63:32]);
		rd(IDX_RDATA2, 32'hffffffff, {24'h0, m[71:64]});
		lat = 4'd0;
		stg(s);
		stall = 1'b1;
		wr(IDX_LAUNCH, 32'h103);
		wr(IDX_LAUNCH, 32'h101);
		wr(IDX_LAUNCH, 32'h102);
		rd(IDX_STATUS, 32'h7, 32'h7);
		rd(6'h23, 32'h80000000, 32'h0);
		wr(IDX_STATUS, 32'h0);
		rd(IDX_STATUS, 32'h2, 32'h0);
		stall = 1'b0;
		repeat (6) @(negedge clk_i);
		cmp("cmds", 80'h4, 80'(n_cmd));
		rd(IDX_STATUS, 32'h7, 32'h0);
		rd(6'h23, 32'hffffffff, rexp(s));
		rd(6'h21, 32'hffffffff, rexp(s));
		rd(6'h22, 32'h80000000, 32'h0);
		wr(IDX_SEMA, 32'h9);
		rst_n_i = 1'b0;
		repeat (2) @(negedge clk_i);
		cmp("reset", 80'h4, {77'h0, sel_n, sdoe, rdata_oe_o});
		rst_n_i = 1'b1;
		rd(IDX_SEMA, 32'hffffffff, 32'h0);
		rd(6'h23, 32'h80000000, 32'h0);
		test_done();
	end
endmodule : scb_bridge_bench
`default_nettype wire
